// ### hdl/est_status_terminal.sv
// Purpose: status leds and serial command terminal of a fibre extender unit
// Assumes: all status inputs are levels synchronous to i_clk
// Notes: in update mode terminal bytes go to o_fw_rx_* for the image loader
// Operation
// R1 - While running normally the system led pulses green slowly.
// R2 - In firmware update mode the system led pulses orange slowly.
// R3 - On a system failure the system led is steady orange.
// R4 - A link led pulses red slowly when no valid low-speed link is seen.
// R5 - A link led is steady red on a camera power fault of that link.
// R6 - Link and fibre leds flash green fast while the link speed is negotiated.
// R7 - Link and fibre leds are steady green once the link is active.
// R8 - A fibre led flashes red fast with no module and is steady red if incompatible.
// R9 - A fibre led pulses red slowly when a module sees no optical signal.
// R10 - The terminal runs 115200 baud, one start bit, one stop bit, no parity.
// R11 - A command is executed only when its carriage return arrives.
// R12 - The firmware command enters update mode, ready for an image transfer.
// R13 - The status command sends a report of system, link and general state.
// R14 - Commands are matched without regard to letter case.
// R15 - A slow rate near 1 Hz and a fast rate near 8 Hz come from one divider.
// R16 - Faults win over negotiation and active patterns; unknown commands are ignored.
`timescale 1ns/1ps
module est_status_terminal
  import est_pkg::*;
#(
  parameter int unsigned N = N_LINKS,
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned BIT_CYCLES = BIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_sys_fail,
  input wire logic [N-1:0] i_cxp_ls_ok,
  input wire logic [N-1:0] i_cxp_pwr_fault,
  input wire logic [N-1:0] i_cxp_negot,
  input wire logic [N-1:0] i_cxp_active,
  input wire logic [N-1:0] i_sfp_present,
  input wire logic [N-1:0] i_sfp_compat,
  input wire logic [N-1:0] i_sfp_sig_ok,
  input wire logic [7:0] i_fw_version,
  input wire logic i_fw_done,
  input wire logic i_uart_rxd,
  output logic o_uart_txd,
  output logic o_sys_led_grn,
  output logic o_sys_led_red,
  output logic [N-1:0] o_cxp_led_grn,
  output logic [N-1:0] o_cxp_led_red,
  output logic [N-1:0] o_sfp_led_grn,
  output logic [N-1:0] o_sfp_led_red,
  output logic o_fw_mode,
  output logic o_fw_rx_valid,
  output logic [7:0] o_fw_rx_data
);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  typedef enum logic {TX_IDLE, TX_RUN} est_tx_t;

  est_uart_if uif ();

  logic [TW-1:0] div_q;
  logic [PHASE_W-1:0] phase_q;
  logic fast_on;
  logic slow_on;
  logic fw_q;
  logic [63:0] cmd_q;
  logic [3:0] len_q;
  logic [7:0] rx_ch;
  logic hit_fw;
  logic hit_st;
  est_tx_t tx_st_q;
  logic ack_q;
  logic [4:0] idx_q;
  logic [4:0] msg_len;
  logic [7:0] tx_byte;
  logic [N-1:0] cxp_ok;
  logic [N-1:0] sfp_ok;
  est_led_t sys_led;
  est_led_t [N-1:0] cxp_led;
  est_led_t [N-1:0] sfp_led;

  // serial engine
  est_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_rxd(i_uart_rxd),
    .o_txd(o_uart_txd),
    .bus(uif.uart)
  );

  // pattern phase: one shared tick keeps every led of the unit in step
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      div_q <= '0;
      phase_q <= '0;
    end else if (div_q == TICK_LAST) begin
      div_q <= '0;
      phase_q <= phase_q + 1'b1; // R15
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign fast_on = phase_q[0]; // R15
  assign slow_on = phase_q[SLOW_BIT]; // R15

  // resolves one pattern against the shared phase
  function automatic logic pat_lit(input est_pat_t pat, input logic slow, input logic fast);
    case (pat)
      LP_SOLID: pat_lit = 1'b1;
      LP_SLOW: pat_lit = slow;
      LP_FAST: pat_lit = fast;
      default: pat_lit = 1'b0;
    endcase
  endfunction : pat_lit

  assign cxp_ok = i_cxp_ls_ok & ~i_cxp_pwr_fault;
  assign sfp_ok = i_sfp_present & i_sfp_compat & i_sfp_sig_ok;

  // led selection, faults first so a faulty link never reads as healthy
  always_comb begin
    sys_led = '{pat: LP_SLOW, grn: 1'b1, red: 1'b0}; // R1
    if (i_sys_fail) begin
      sys_led = '{pat: LP_SOLID, grn: 1'b1, red: 1'b1}; // R3
    end else if (fw_q) begin
      sys_led = '{pat: LP_SLOW, grn: 1'b1, red: 1'b1}; // R2
    end
    for (int k = 0; k < N; k++) begin
      cxp_led[k] = '{pat: LP_OFF, grn: 1'b0, red: 1'b0};
      sfp_led[k] = '{pat: LP_OFF, grn: 1'b0, red: 1'b0};
      if (i_cxp_pwr_fault[k]) begin
        cxp_led[k] = '{pat: LP_SOLID, grn: 1'b0, red: 1'b1}; // R5 R16
      end else if (!i_cxp_ls_ok[k]) begin
        cxp_led[k] = '{pat: LP_SLOW, grn: 1'b0, red: 1'b1}; // R4
      end else if (i_cxp_negot[k]) begin
        cxp_led[k] = '{pat: LP_FAST, grn: 1'b1, red: 1'b0}; // R6
      end else if (i_cxp_active[k]) begin
        cxp_led[k] = '{pat: LP_SOLID, grn: 1'b1, red: 1'b0}; // R7
      end
      if (!i_sfp_present[k]) begin
        sfp_led[k] = '{pat: LP_FAST, grn: 1'b0, red: 1'b1}; // R8 R16
      end else if (!i_sfp_compat[k]) begin
        sfp_led[k] = '{pat: LP_SOLID, grn: 1'b0, red: 1'b1}; // R8
      end else if (!i_sfp_sig_ok[k]) begin
        sfp_led[k] = '{pat: LP_SLOW, grn: 1'b0, red: 1'b1}; // R9
      end else if (i_cxp_negot[k]) begin
        sfp_led[k] = '{pat: LP_FAST, grn: 1'b1, red: 1'b0}; // R6
      end else if (i_cxp_active[k]) begin
        sfp_led[k] = '{pat: LP_SOLID, grn: 1'b1, red: 1'b0}; // R7
      end
    end
  end

  // led drivers are registered; update mode blanks all but the system led
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_sys_led_grn <= 1'b0;
      o_sys_led_red <= 1'b0;
      o_cxp_led_grn <= '0;
      o_cxp_led_red <= '0;
      o_sfp_led_grn <= '0;
      o_sfp_led_red <= '0;
    end else begin
      o_sys_led_grn <= sys_led.grn & pat_lit(sys_led.pat, slow_on, fast_on);
      o_sys_led_red <= sys_led.red & pat_lit(sys_led.pat, slow_on, fast_on);
      for (int k = 0; k < N; k++) begin
        o_cxp_led_grn[k] <= !fw_q && cxp_led[k].grn && pat_lit(cxp_led[k].pat, slow_on, fast_on);
        o_cxp_led_red[k] <= !fw_q && cxp_led[k].red && pat_lit(cxp_led[k].pat, slow_on, fast_on);
        o_sfp_led_grn[k] <= !fw_q && sfp_led[k].grn && pat_lit(sfp_led[k].pat, slow_on, fast_on);
        o_sfp_led_red[k] <= !fw_q && sfp_led[k].red && pat_lit(sfp_led[k].pat, slow_on, fast_on);
      end
    end
  end

  // command matching on the folded line; matches count only at carriage return
  assign rx_ch = est_fold(uif.rx_data); // R14
  assign hit_fw = uif.rx_valid && !fw_q && uif.rx_data == CH_CR
                  && len_q == 4'(CMD_FW_LEN) && cmd_q == CMD_FW; // R11 R12
  assign hit_st = uif.rx_valid && !fw_q && uif.rx_data == CH_CR
                  && len_q == 4'(CMD_ST_LEN) && cmd_q[47:0] == CMD_ST; // R11 R13

  // line collector; an overlong line saturates and can match nothing
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cmd_q <= '0;
      len_q <= '0;
    end else if (uif.rx_valid && !fw_q) begin
      if (uif.rx_data == CH_CR) begin
        len_q <= '0; // R11 R16
        cmd_q <= '0;
      end else if (uif.rx_data != CH_LF) begin
        cmd_q <= {cmd_q[55:0], rx_ch};
        len_q <= (len_q > 4'(CMD_MAX)) ? len_q : len_q + 1'b1;
      end
    end
  end

  // update mode lasts until the image loader reports an end, good or bad
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      fw_q <= 1'b0;
    end else if (hit_fw) begin
      fw_q <= 1'b1; // R12
    end else if (i_fw_done) begin
      fw_q <= 1'b0;
    end
  end
  assign o_fw_mode = fw_q;

  // image bytes pass straight through while in update mode
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_fw_rx_valid <= 1'b0;
      o_fw_rx_data <= '0;
    end else begin
      o_fw_rx_valid <= fw_q && uif.rx_valid; // R12
      o_fw_rx_data <= uif.rx_data;
    end
  end

  // message bytes: acknowledge, or report with live state per byte
  always_comb begin
    msg_len = ack_q ? 5'(ACK_LEN) : 5'(REP_LEN);
    tx_byte = CH_LF;
    if (ack_q) begin
      case (idx_q)
        5'd0: tx_byte = CH_FAIL;
        5'd1: tx_byte = CH_W;
        5'd2: tx_byte = CH_CR;
        default: tx_byte = CH_LF;
      endcase
    end else if (idx_q >= 5'(REP_LINK0) && idx_q < 5'(REP_LINK0 + N)) begin
      for (int k = 0; k < N; k++) begin
        if (idx_q == 5'(REP_LINK0 + k)) begin
          tx_byte = est_hex({i_cxp_active[k], i_cxp_negot[k], sfp_ok[k], cxp_ok[k]}); // R13
        end
      end
    end else begin
      case (idx_q)
        5'd0: tx_byte = CH_S;
        5'd1: tx_byte = i_sys_fail ? CH_FAIL : (fw_q ? CH_UPD : CH_OK); // R13
        5'd2: tx_byte = CH_V;
        5'd3: tx_byte = est_hex(i_fw_version[7:4]); // R13
        5'd4: tx_byte = est_hex(i_fw_version[3:0]);
        5'd5: tx_byte = CH_L;
        5'(REP_LEN - 2): tx_byte = CH_CR;
        default: tx_byte = CH_LF;
      endcase
    end
  end

  // reply sequencer; a command arriving mid-reply gets no reply of its own, none is queued
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tx_st_q <= TX_IDLE;
      ack_q <= 1'b0;
      idx_q <= '0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          idx_q <= '0;
          if (hit_fw || hit_st) begin
            tx_st_q <= TX_RUN; // R12 R13
            ack_q <= hit_fw;
          end
        end
        TX_RUN: begin
          if (uif.tx_ready) begin
            idx_q <= idx_q + 1'b1;
            if (idx_q == msg_len - 1'b1) begin
              tx_st_q <= TX_IDLE;
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end
  assign uif.tx_valid = (tx_st_q == TX_RUN);
  assign uif.tx_data = tx_byte;
endmodule : est_status_terminal

// ### hdl/est_uart.sv
// Purpose: 8N1 serial receiver and transmitter for the terminal port
// Assumes: rxd already synchronous to i_clk
// Notes: no parity and no flow control; a bad stop bit drops the byte
`timescale 1ns/1ps
module est_uart
  import est_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_rxd,
  output logic o_txd,
  est_uart_if.uart bus
);
  localparam int CW = $clog2(BIT_CYCLES);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYCLES / 2);

  logic [CW-1:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_busy_q;
  logic [CW-1:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [9:0] tx_sh_q;

  // receiver: start edge, check at mid bit, then one sample per bit time
  always_ff @(posedge i_clk) begin
    bus.rx_valid <= 1'b0;
    if (!i_rstn) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      bus.rx_data <= '0;
    end else if (!rx_busy_q) begin
      if (!i_rxd) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q <= BIT_HALF;
        rx_bit_q <= '0;
      end
    end else if (rx_cnt_q != '0) begin
      rx_cnt_q <= rx_cnt_q - 1'b1;
    end else begin
      rx_cnt_q <= BIT_LAST;
      rx_bit_q <= rx_bit_q + 1'b1;
      if (rx_bit_q == 4'd0 && i_rxd) begin
        rx_busy_q <= 1'b0; // glitch, not a start bit
      end else if (rx_bit_q == 4'd9) begin
        rx_busy_q <= 1'b0;
        bus.rx_valid <= i_rxd; // R10
        bus.rx_data <= rx_sh_q;
      end else if (rx_bit_q != 4'd0) begin
        rx_sh_q <= {i_rxd, rx_sh_q[7:1]}; // lsb first
      end
    end
  end

  assign bus.tx_ready = (tx_bit_q == 4'd0);

  // transmitter: start, eight data bits lsb first, one stop bit
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tx_sh_q <= '1;
      tx_bit_q <= '0;
      tx_cnt_q <= '0;
    end else if (tx_bit_q == 4'd0) begin
      if (bus.tx_valid) begin
        tx_sh_q <= {1'b1, bus.tx_data, 1'b0}; // R10
        tx_bit_q <= 4'd10;
        tx_cnt_q <= BIT_LAST;
      end
    end else if (tx_cnt_q != '0) begin
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end else begin
      tx_cnt_q <= BIT_LAST;
      tx_bit_q <= tx_bit_q - 1'b1;
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
    end
  end

  // pin comes straight from the shifter flop, which refills with ones, so no glitch
  assign o_txd = tx_sh_q[0];
endmodule : est_uart

// ### inc/est_pkg.sv
// Purpose: shared constants and types of the extender status and terminal block
// Assumes: 200 MHz system clock, one bi-colour led is a green and a red drive
// Notes: orange is shown by lighting green and red together
package est_pkg;
  // clock and serial timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BAUD_RATE = 115_200;
  localparam int unsigned BIT_CYC = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  // indicator rates in hertz, both taken from one 2*FAST_HZ tick
  localparam int unsigned FAST_HZ = 8;
  localparam int unsigned SLOW_HZ = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / (2 * FAST_HZ);
  localparam int unsigned SLOW_BIT = $clog2(FAST_HZ / SLOW_HZ);
  localparam int unsigned PHASE_W = SLOW_BIT + 1;
  localparam int unsigned N_LINKS = 4;
  // terminal characters
  localparam int unsigned CMD_MAX = 8;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_UP_A = 8'h41;
  localparam logic [7:0] CH_UP_Z = 8'h5a;
  localparam logic [7:0] CASE_OFS = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_HEX_A = 8'h57;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_V = 8'h56;
  localparam logic [7:0] CH_L = 8'h4c;
  localparam logic [7:0] CH_OK = 8'h4f;
  localparam logic [7:0] CH_FAIL = 8'h46;
  localparam logic [7:0] CH_UPD = 8'h55;
  localparam logic [7:0] CH_W = 8'h57;
  // lower-case command spellings
  localparam logic [63:0] CMD_FW = 64'h6669726d77617265;
  localparam logic [47:0] CMD_ST = 48'h737461747573;
  localparam int unsigned CMD_FW_LEN = 8;
  localparam int unsigned CMD_ST_LEN = 6;
  // report layout: S x V hh L links CR LF
  localparam int unsigned REP_LINK0 = 6;
  localparam int unsigned REP_LEN = REP_LINK0 + N_LINKS + 2;
  localparam int unsigned ACK_LEN = 4;

  typedef enum logic [1:0] {LP_OFF, LP_SOLID, LP_SLOW, LP_FAST} est_pat_t;
  typedef struct packed {
    est_pat_t pat;
    logic grn;
    logic red;
  } est_led_t;

  // one nibble as a lower-case hex digit
  function automatic logic [7:0] est_hex(input logic [3:0] nib);
    est_hex = (nib < 4'ha) ? CH_ZERO + {4'h0, nib} : CH_HEX_A + {4'h0, nib};
  endfunction : est_hex

  // folds upper-case letters to lower case, other bytes unchanged
  function automatic logic [7:0] est_fold(input logic [7:0] ch);
    est_fold = (ch >= CH_UP_A && ch <= CH_UP_Z) ? ch + CASE_OFS : ch;
  endfunction : est_fold
endpackage : est_pkg

// ### inc/est_uart_if.sv
// Purpose: byte carrier between the terminal logic and its serial engine
// Assumes: single clock domain
// Notes: rx_valid is a one-cycle pulse; tx uses valid/ready
`timescale 1ns/1ps
interface est_uart_if;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] rx_data;
  logic rx_valid;
  modport uart (input tx_data, input tx_valid, output tx_ready, output rx_data,
                output rx_valid);
  modport term (output tx_data, output tx_valid, input tx_ready, input rx_data,
                input rx_valid);
endinterface : est_uart_if

// ### test/est_host_term.sv
// Purpose: host terminal model on the far side of the serial port
// Assumes: 8N1 framing at BIT_CYCLES clocks per bit
// Notes: reply bytes gather in rx_q for the bench
`timescale 1ns/1ps
module est_host_term #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  logic [7:0] rx_q[$];
  initial o_rxd = 1'b1;
  // start bit, data lsb first, stop bit; gap idles a slow typist
  task automatic send_byte(input logic [7:0] b, input int gap);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge i_clk);
      o_rxd = fr[i];
      repeat (BIT_CYCLES - 1) @(negedge i_clk);
    end
    repeat (gap) @(negedge i_clk);
  endtask : send_byte
  // letters only; the carriage return is sent on its own
  task automatic send_str(input string s, input int gap);
    for (int i = 0; i < s.len(); i++) send_byte(s[i], gap);
  endtask : send_str
  // sample mid-bit; a frame whose stop bit is low is dropped
  always begin : rx_proc
    logic [7:0] b;
    @(negedge i_txd);
    repeat (BIT_CYCLES / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge i_clk);
      b[i] = i_txd;
    end
    repeat (BIT_CYCLES) @(posedge i_clk);
    if (i_txd === 1'b1) rx_q.push_back(b);
  end
endmodule : est_host_term

// ### test/est_status_terminal_properties.sv
// Purpose: port-level checks of the status leds and terminal
// Assumes: one clock, synchronous active-low reset
// Notes: slow and fast leds stay dark until the first tick, so steady checks wait
`timescale 1ns/1ps
module est_status_terminal_properties
  import est_pkg::*;
#(
  parameter int unsigned N = N_LINKS,
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_sys_fail,
  input wire logic [N-1:0] i_cxp_ls_ok,
  input wire logic [N-1:0] i_cxp_pwr_fault,
  input wire logic [N-1:0] i_cxp_negot,
  input wire logic [N-1:0] i_cxp_active,
  input wire logic [N-1:0] i_sfp_present,
  input wire logic [N-1:0] i_sfp_compat,
  input wire logic i_fw_done,
  input wire logic o_uart_txd,
  input wire logic o_sys_led_grn,
  input wire logic o_sys_led_red,
  input wire logic [N-1:0] o_cxp_led_grn,
  input wire logic [N-1:0] o_cxp_led_red,
  input wire logic [N-1:0] o_sfp_led_grn,
  input wire logic [N-1:0] o_sfp_led_red,
  input wire logic o_fw_mode,
  input wire logic o_fw_rx_valid
);
  logic [31:0] up_q;
  logic warm;
  logic [N-1:0] act_ok;
  logic [N-1:0] incompat;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // cycles since reset, saturating once past the first tick
  always_ff @(posedge i_clk) begin
    if (!i_rstn) up_q <= 32'h0;
    else if (!warm) up_q <= up_q + 32'h1;
  end
  assign warm = (up_q > TICK_CYCLES + 1);
  // links that should show plain steady green, and fibres with a wrong module
  assign act_ok = i_cxp_active & i_cxp_ls_ok & ~i_cxp_pwr_fault & ~i_cxp_negot;
  assign incompat = i_sfp_present & ~i_sfp_compat;
  property p_sys_fail;
    warm && i_sys_fail |=> o_sys_led_grn && o_sys_led_red;
  endproperty
  a_sys_fail: assert property (p_sys_fail) else $error("fail led not steady orange");
  property p_sys_norm;
    warm && !i_sys_fail && !o_fw_mode |=> !o_sys_led_red;
  endproperty
  a_sys_norm: assert property (p_sys_norm) else $error("system led not green");
  property p_pwr;
    warm && !o_fw_mode |=> ((o_cxp_led_red & $past(i_cxp_pwr_fault)) == $past(i_cxp_pwr_fault))
      && ((o_cxp_led_grn & $past(i_cxp_pwr_fault)) == '0);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power fault not steady red");
  property p_active;
    warm && !o_fw_mode |=> (o_cxp_led_grn & $past(act_ok)) == $past(act_ok);
  endproperty
  a_active: assert property (p_active) else $error("active link not green");
  property p_incompat;
    warm && !o_fw_mode |=> ((o_sfp_led_red & $past(incompat)) == $past(incompat))
      && ((o_sfp_led_grn & $past(incompat)) == '0);
  endproperty
  a_incompat: assert property (p_incompat) else $error("bad module not red");
  property p_blank;
    o_fw_mode |=> (o_cxp_led_grn | o_cxp_led_red | o_sfp_led_grn | o_sfp_led_red) == '0;
  endproperty
  a_blank: assert property (p_blank) else $error("link leds lit in update");
  property p_exit;
    o_fw_mode && i_fw_done |=> !o_fw_mode;
  endproperty
  a_exit: assert property (p_exit) else $error("update mode did not end");
  property p_rx_pulse;
    o_fw_rx_valid |=> !o_fw_rx_valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("image byte pulse too long");
  property p_start;
    $fell(o_uart_txd) |-> !o_uart_txd [*8];
  endproperty
  a_start: assert property (p_start) else $error("start bit too short");
endmodule : est_status_terminal_properties
bind est_status_terminal est_status_terminal_properties #(.N(N), .TICK_CYCLES(TICK_CYCLES))
  u_props (.*);

// ### test/est_status_terminal_tb.sv
// Purpose: self-checking bench of the status leds and serial terminal
// Assumes: short tick and bit counts keep patterns and frames brief
// Notes: table rows drive every link alike; the report test varies links
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module est_status_terminal_tb;
  localparam int unsigned NL = 4;
  localparam int unsigned TK = 4;
  localparam int unsigned BC = 16;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_sys_fail = 1'b0, i_fw_done = 1'b0;
  logic [NL-1:0] ls = '0, pw = '0, ng = '0, ac = '0, pr = '0, cp = '0, sg = '0;
  logic [NL-1:0] cxp_g, cxp_r, sfp_g, sfp_r;
  logic [7:0] ver = 8'h3c;
  logic [7:0] fw_data, fw_last;
  logic rxd, txd, fw_mode, fw_vld, sys_g, sys_r;
  logic [7:0] exp_q[$];
  int bad_count = 0, checks = 0, cyc = 0, pulses = 0;
  // inputs {fail ls pwr negot active present compat sig}, then 2-bit codes
  // for sys g/r, link g/r, fibre g/r: 0 dark, 1 steady, 2 slow, 3 fast
  logic [19:0] rows [8] = '{20'h4f844, 20'h7781c, 20'h07820, 20'h578cc,
                            20'h48843, 20'h4d841, 20'h4e842, 20'hcf544};
  est_status_terminal #(.N(NL), .TICK_CYCLES(TK), .BIT_CYCLES(BC)) u_est_status_terminal (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_sys_fail(i_sys_fail), .i_cxp_ls_ok(ls),
    .i_cxp_pwr_fault(pw), .i_cxp_negot(ng), .i_cxp_active(ac), .i_sfp_present(pr),
    .i_sfp_compat(cp), .i_sfp_sig_ok(sg), .i_fw_version(ver), .i_fw_done(i_fw_done),
    .i_uart_rxd(rxd), .o_uart_txd(txd), .o_sys_led_grn(sys_g), .o_sys_led_red(sys_r),
    .o_cxp_led_grn(cxp_g), .o_cxp_led_red(cxp_r), .o_sfp_led_grn(sfp_g),
    .o_sfp_led_red(sfp_r), .o_fw_mode(fw_mode), .o_fw_rx_valid(fw_vld),
    .o_fw_rx_data(fw_data));
  est_host_term #(.BIT_CYCLES(BC)) u_est_host_term (.i_clk(i_clk), .i_txd(txd), .o_rxd(rxd));
  always #2.5 i_clk = ~i_clk;
  // hang guard, about three times the twelve thousand or so cycles the run needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  // count image bytes handed to the loader
  always @(negedge i_clk) if (fw_vld === 1'b1) begin
    pulses++;
    fw_last = fw_data;
  end
  function automatic logic [7:0] hexch(input logic [3:0] n);
    hexch = (n < 4'ha) ? 8'h30 + 8'(n) : 8'h57 + 8'(n);
  endfunction : hexch
  // classify six led lines over 128 cycles by their transition count
  task automatic measure(input logic [11:0] e);
    logic [5:0] v, p, on, off;
    logic [11:0] got;
    int tr[6];
    on = '0;
    off = '0;
    tr = '{default: 0};
    @(negedge i_clk);
    p = {sys_g, sys_r, cxp_g[0], cxp_r[0], sfp_g[0], sfp_r[0]};
    repeat (128) begin
      @(negedge i_clk);
      v = {sys_g, sys_r, cxp_g[0], cxp_r[0], sfp_g[0], sfp_r[0]};
      on |= v;
      off |= ~v;
      for (int k = 0; k < 6; k++) if (v[k] !== p[k]) tr[k]++;
      p = v;
    end
    for (int k = 0; k < 6; k++)
      got[2*k +: 2] = (tr[k] > 8) ? 2'h3 : (tr[k] > 0) ? 2'h2 : {1'b0, on[k] & ~off[k]};
    `CHK("led patterns", e, got)
  endtask : measure
  // wait for the whole reply, then compare it byte by byte
  task automatic expect_reply();
    int n;
    n = 0;
    while (u_est_host_term.rx_q.size() < exp_q.size() && n < 4000) begin
      @(negedge i_clk);
      n++;
    end
    repeat (4 * BC) @(negedge i_clk);
    `CHK("reply length", exp_q.size(), u_est_host_term.rx_q.size())
    foreach (exp_q[i]) `CHK("reply byte", exp_q[i], u_est_host_term.rx_q[i])
    u_est_host_term.rx_q.delete();
  endtask : expect_reply
  task automatic wrap_up();
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8) @(negedge i_clk);
    `CHK("txd in reset", 1'b1, txd)
    `CHK("mode in reset", 1'b0, fw_mode)
    i_rstn = 1'b1;
    foreach (rows[r]) begin
      @(negedge i_clk);
      i_sys_fail = rows[r][19];
      {ls, pw, ng, ac} = {{NL{rows[r][18]}}, {NL{rows[r][17]}}, {NL{rows[r][16]}},
                          {NL{rows[r][15]}}};
      {pr, cp, sg} = {{NL{rows[r][14]}}, {NL{rows[r][13]}}, {NL{rows[r][12]}}};
      measure(rows[r][11:0]);
    end
    // each link a different mix, so every link digit of the report differs
    @(negedge i_clk);
    i_sys_fail = 1'b0;
    {ls, pw, ng, ac} = {4'hb, 4'h4, 4'h2, 4'h1};
    {pr, cp, sg} = {4'hf, 4'hd, 4'hf};
    u_est_host_term.send_str("StAtUs", 30);
    repeat (400) @(negedge i_clk);
    `CHK("early reply", 0, u_est_host_term.rx_q.size())
    u_est_host_term.send_byte(8'h0d, 0);
    exp_q = '{8'h53, 8'h4f, 8'h56, hexch(ver[7:4]), hexch(ver[3:0]), 8'h4c};
    for (int i = 0; i < NL; i++)
      exp_q.push_back(hexch({ac[i], ng[i], pr[i] & cp[i] & sg[i], ls[i] & ~pw[i]}));
    exp_q.push_back(8'h0d);
    exp_q.push_back(8'h0a);
    expect_reply();
    // a near miss and a bare line feed draw no answer
    u_est_host_term.send_str("statux", 0);
    u_est_host_term.send_byte(8'h0d, 0);
    u_est_host_term.send_byte(8'h0a, 0);
    repeat (400) @(negedge i_clk);
    `CHK("unknown reply", 0, u_est_host_term.rx_q.size())
    // a failed unit must say so in the state field of the report
    i_sys_fail = 1'b1;
    u_est_host_term.send_str("STATUS", 0);
    u_est_host_term.send_byte(8'h0d, 0);
    exp_q[1] = 8'h46;
    expect_reply();
    i_sys_fail = 1'b0;
    u_est_host_term.send_str("FirmWare", 0);
    u_est_host_term.send_byte(8'h0d, 0);
    exp_q = '{8'h46, 8'h57, 8'h0d, 8'h0a};
    expect_reply();
    `CHK("update mode", 1'b1, fw_mode)
    measure(12'ha00);
    u_est_host_term.send_byte(8'ha5, 0);
    repeat (BC) @(negedge i_clk);
    `CHK("image bytes", 1, pulses)
    `CHK("image data", 8'ha5, fw_last)
    i_fw_done = 1'b1;
    @(negedge i_clk);
    i_fw_done = 1'b0;
    `CHK("update exit", 1'b0, fw_mode)
    wrap_up();
  end
endmodule : est_status_terminal_tb
